/* common/vcdi_pkg.sv */
// Shared constants and types for the vector core dual-issue control
package vcdi_pkg;

	// ----------------------------------------
	// Instruction format and register file
	// ----------------------------------------
	localparam int          INSTR_BYTES = 4;
	localparam int          ALIGN_BITS  = 2;
	localparam int          NUM_VREGS   = 128;
	localparam int          REG_W       = 7;
	localparam int          QWORD_BYTES = 16;
	localparam int          QWORD_W     = QWORD_BYTES * 8;
	localparam int          MUL_W       = 16;
	localparam int          CHAN_W      = 7;
	localparam int          NUM_CHANS   = 128;
	localparam int          CNT_W       = 4;

	// ----------------------------------------
	// Pipelines
	// ----------------------------------------
	localparam logic        PIPE_EVEN   = 1'h0;
	localparam logic        PIPE_ODD    = 1'h1;

	// ----------------------------------------
	// Instruction classes as seen by the scheduler
	// ----------------------------------------
	typedef enum logic [3:0] {
		CLS_ADD_LOGIC,
		CLS_BYTE_AVG,
		CLS_BR_IND,
		CLS_BR_LINK,
		CLS_DP_FLOAT,
		CLS_MPY16,
		CLS_CH_READ,
		CLS_CH_WRITE,
		CLS_CH_COUNT,
		CLS_SYNC_FLUSH
	} vcdi_cls_e;

	// ----------------------------------------
	// Latencies (stall cycles already included) and stalls
	// ----------------------------------------
	localparam logic [CNT_W-1:0] LAT_NONE     = 4'h0;
	localparam logic [CNT_W-1:0] LAT_ADD      = 4'h2;
	localparam logic [CNT_W-1:0] LAT_BYTE_AVG = 4'h4;
	localparam logic [CNT_W-1:0] LAT_BR_LINK  = 4'h4;
	localparam logic [CNT_W-1:0] LAT_DP       = 4'h7;
	localparam logic [CNT_W-1:0] LAT_MPY      = 4'h7;
	localparam logic [CNT_W-1:0] LAT_CHAN     = 4'h6;
	localparam logic [CNT_W-1:0] STALL_DP     = 4'h6;
	localparam logic [CNT_W-1:0] CHAN_WINDOW  = 4'h5;
	localparam logic [CNT_W-1:0] FLUSH_RECOV  = 4'h6;

	// ----------------------------------------
	// Event channels that collide with each other
	// ----------------------------------------
	localparam logic [CHAN_W-1:0] EVENT_STATUS_CHANNEL      = 7'h00;
	localparam logic [CHAN_W-1:0] EVENT_MASK_CHANNEL        = 7'h01;
	localparam logic [CHAN_W-1:0] EVENT_ACKNOWLEDGE_CHANNEL = 7'h02;

endpackage : vcdi_pkg

/* hdl/vcdi_mul16.sv */
// Narrow 16 x 16 multiplier of the even pipeline
`timescale 1ns/1ps
module vcdi_mul16 (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         rstn,
	// Operands
	input  wire logic                         go,
	input  wire logic [vcdi_pkg::MUL_W-1:0]   op_a,
	input  wire logic [vcdi_pkg::MUL_W-1:0]   op_b,
	// Product
	output logic      [2*vcdi_pkg::MUL_W-1:0] prod
);
	import vcdi_pkg::*;

	logic [2*MUL_W-1:0] prod_r;
	logic [2*MUL_W-1:0] prod_nxt;

	// Wider products are built by software from several of these
	always_comb begin
		prod_nxt = prod_r;
		if (go) begin
			prod_nxt = op_a * op_b;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			prod_r <= '0;
		end else begin
			prod_r <= prod_nxt;
		end
	end

	assign prod = prod_r;

endmodule : vcdi_mul16

/* hdl/vcdi_issue_ctl.sv */
// Dual-issue scheduler: pipe steering, scoreboard, stalls, channel holds and flushes
`timescale 1ns/1ps
// Functional notes
// - Instructions are four bytes; a word-misaligned address faults and never issues.
// - Scoreboard covers all 128 vector registers; load/store data is 16 bytes.
// - Even pipe 0 and odd pipe 1, at most one issue each per cycle.
// - Tracked latency already contains stall cycles; nothing extra is added.
// - After a 6-cycle stall op, next same-type op issues 7 cycles later.
// - Multiplier handles only 16 by 16 products.
// - Add, borrow and logical ops go even with latency 2, no stall.
// - Byte absolute difference and average go even with latency 4.
// - Indirect branches go odd, no stall, no register result.
// - Indirect branch with link goes odd; link ready after 4 cycles.
// - Blocking channel access waits until that channel count is nonzero.
// - Second channel access within five cycles to same/event channel is flushed.
// - Flushing instructions cause recovery cycles with no forward progress.
module vcdi_issue_ctl (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rstn,
	// Fetched candidates, slot 0 older
	input  wire logic                          slot_vld  [2],
	input  wire logic [31:0]                   slot_addr [2],
	input  vcdi_pkg::vcdi_cls_e                slot_cls  [2],
	input  wire logic [vcdi_pkg::REG_W-1:0]    slot_src  [2][2],
	input  wire logic [1:0]                    slot_src_en [2],
	input  wire logic [vcdi_pkg::REG_W-1:0]    slot_dst  [2],
	input  wire logic                          slot_dst_en [2],
	input  wire logic [vcdi_pkg::CHAN_W-1:0]   slot_chan [2],
	input  wire logic                          slot_chan_blk [2],
	output logic                               slot_take [2],
	// Channel interface status
	input  wire logic [vcdi_pkg::NUM_CHANS-1:0] chan_cnt_nz,
	// Multiplier operands and product
	input  wire logic [vcdi_pkg::MUL_W-1:0]    mul_a,
	input  wire logic [vcdi_pkg::MUL_W-1:0]    mul_b,
	output logic      [2*vcdi_pkg::MUL_W-1:0]  mul_prod,
	// Issue outputs
	output logic                               ev_vld_r,
	output logic [31:0]                        ev_addr_r,
	output vcdi_pkg::vcdi_cls_e                ev_cls_r,
	output logic                               od_vld_r,
	output logic [31:0]                        od_addr_r,
	output vcdi_pkg::vcdi_cls_e                od_cls_r,
	// Flush and fault
	output logic                               flush_r,
	output logic [31:0]                        flush_addr_r,
	output logic                               fault_r
);
	import vcdi_pkg::*;

	// ----------------------------------------
	// Class attributes
	// ----------------------------------------
	function automatic logic pipe_of(input vcdi_cls_e c);
		unique case (c)
			CLS_ADD_LOGIC, CLS_BYTE_AVG, CLS_DP_FLOAT, CLS_MPY16: pipe_of = PIPE_EVEN;
			CLS_BR_IND, CLS_BR_LINK, CLS_CH_READ, CLS_CH_WRITE,
			CLS_CH_COUNT, CLS_SYNC_FLUSH:                         pipe_of = PIPE_ODD;
		endcase
	endfunction : pipe_of

	function automatic logic [CNT_W-1:0] lat_of(input vcdi_cls_e c);
		unique case (c)
			CLS_ADD_LOGIC:  lat_of = LAT_ADD;
			CLS_BYTE_AVG:   lat_of = LAT_BYTE_AVG;
			CLS_BR_IND:     lat_of = LAT_NONE;
			CLS_BR_LINK:    lat_of = LAT_BR_LINK;
			CLS_DP_FLOAT:   lat_of = LAT_DP;
			CLS_MPY16:      lat_of = LAT_MPY;
			CLS_CH_READ, CLS_CH_WRITE, CLS_CH_COUNT: lat_of = LAT_CHAN;
			CLS_SYNC_FLUSH: lat_of = LAT_NONE;
		endcase
	endfunction : lat_of

	function automatic logic is_chan(input vcdi_cls_e c);
		is_chan = (c == CLS_CH_READ) || (c == CLS_CH_WRITE) || (c == CLS_CH_COUNT);
	endfunction : is_chan

	function automatic logic is_evt(input logic [CHAN_W-1:0] ch);
		is_evt = (ch == EVENT_STATUS_CHANNEL) || (ch == EVENT_MASK_CHANNEL)
			|| (ch == EVENT_ACKNOWLEDGE_CHANNEL);
	endfunction : is_evt

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [CNT_W-1:0]  busy_r [NUM_VREGS];
	logic [CNT_W-1:0]  busy_nxt [NUM_VREGS];
	logic [CNT_W-1:0]  dp_stall_r, dp_stall_nxt;
	logic [CNT_W-1:0]  ch_age_r, ch_age_nxt;
	logic [CHAN_W-1:0] ch_last_r, ch_last_nxt;
	logic [CNT_W-1:0]  recov_r, recov_nxt;
	logic              ev_vld_nxt, od_vld_nxt, flush_nxt, fault_nxt;
	logic [31:0]       ev_addr_nxt, od_addr_nxt, flush_addr_nxt;
	vcdi_cls_e         ev_cls_nxt, od_cls_nxt;

	logic              go [2];
	logic              retry [2];
	logic              bad [2];
	logic              ready [2];
	logic              hz [2];

	// ----------------------------------------
	// Per-slot readiness
	// ----------------------------------------
	for (genvar s = 0; s < 2; s++) begin : g_slot
		assign bad[s] = slot_vld[s] && (slot_addr[s][ALIGN_BITS-1:0] != '0);
		assign hz[s] = (slot_src_en[s][0] && busy_r[slot_src[s][0]] != '0)
			|| (slot_src_en[s][1] && busy_r[slot_src[s][1]] != '0);
		assign retry[s] = is_chan(slot_cls[s]) && ch_age_r != '0
			&& (slot_chan[s] == ch_last_r || (is_evt(slot_chan[s]) && is_evt(ch_last_r)));
		assign ready[s] = slot_vld[s] && !bad[s] && !hz[s] && recov_r == '0
			&& !(slot_cls[s] == CLS_DP_FLOAT && dp_stall_r != '0)
			&& !(is_chan(slot_cls[s]) && slot_chan_blk[s] && !chan_cnt_nz[slot_chan[s]]);
	end

	always_comb begin
		go[0] = ready[0] && !retry[0];
		// younger waits on pipe clash or dependence on the older
		go[1] = go[0] && ready[1] && !retry[1]
			&& pipe_of(slot_cls[1]) != pipe_of(slot_cls[0])
			&& !is_chan(slot_cls[0]) && slot_cls[0] != CLS_SYNC_FLUSH
			&& !(slot_dst_en[0] && ((slot_src_en[1][0] && slot_src[1][0] == slot_dst[0])
				|| (slot_src_en[1][1] && slot_src[1][1] == slot_dst[0])));
		slot_take[0] = go[0] || (recov_r == '0 && (bad[0] || (ready[0] && retry[0])));
		slot_take[1] = go[1];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		for (int r = 0; r < NUM_VREGS; r++) begin
			busy_nxt[r] = (busy_r[r] != '0) ? busy_r[r] - 1'b1 : busy_r[r];
		end
		dp_stall_nxt   = (dp_stall_r != '0) ? dp_stall_r - 1'b1 : dp_stall_r;
		ch_age_nxt     = (ch_age_r != '0) ? ch_age_r - 1'b1 : ch_age_r;
		ch_last_nxt    = ch_last_r;
		recov_nxt      = (recov_r != '0) ? recov_r - 1'b1 : recov_r;
		ev_vld_nxt     = 1'b0;
		od_vld_nxt     = 1'b0;
		ev_addr_nxt    = ev_addr_r;
		od_addr_nxt    = od_addr_r;
		ev_cls_nxt     = ev_cls_r;
		od_cls_nxt     = od_cls_r;
		flush_nxt      = 1'b0;
		flush_addr_nxt = flush_addr_r;
		fault_nxt      = 1'b0;
		for (int s = 0; s < 2; s++) begin
			if (go[s]) begin
				// producer marks its target busy for latency minus one
				if (slot_dst_en[s] && lat_of(slot_cls[s]) != LAT_NONE) begin
					busy_nxt[slot_dst[s]] = lat_of(slot_cls[s]) - 1'b1;
				end
				// block same-type issue for the stall count
				if (slot_cls[s] == CLS_DP_FLOAT) begin
					dp_stall_nxt = STALL_DP;
				end
				if (is_chan(slot_cls[s])) begin
					ch_age_nxt  = CHAN_WINDOW;
					ch_last_nxt = slot_chan[s];
				end
				if (pipe_of(slot_cls[s]) == PIPE_EVEN) begin
					ev_vld_nxt  = 1'b1;
					ev_addr_nxt = slot_addr[s];
					ev_cls_nxt  = slot_cls[s];
				end else begin
					od_vld_nxt  = 1'b1;
					od_addr_nxt = slot_addr[s];
					od_cls_nxt  = slot_cls[s];
				end
				if (slot_cls[s] == CLS_SYNC_FLUSH) begin
					flush_nxt      = 1'b1;
					flush_addr_nxt = slot_addr[s] + INSTR_BYTES;
					recov_nxt      = FLUSH_RECOV;
				end
			end
		end
		// refetch the colliding channel access after recovery
		if (recov_r == '0 && ready[0] && retry[0]) begin
			flush_nxt      = 1'b1;
			flush_addr_nxt = slot_addr[0];
			recov_nxt      = FLUSH_RECOV;
		end
		// misaligned instruction is dropped with a fault
		if (recov_r == '0 && bad[0]) begin
			fault_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int r = 0; r < NUM_VREGS; r++) begin
				busy_r[r] <= '0;
			end
			dp_stall_r   <= '0;
			ch_age_r     <= '0;
			ch_last_r    <= '0;
			recov_r      <= '0;
			ev_vld_r     <= 1'b0;
			od_vld_r     <= 1'b0;
			ev_addr_r    <= '0;
			od_addr_r    <= '0;
			ev_cls_r     <= CLS_ADD_LOGIC;
			od_cls_r     <= CLS_BR_IND;
			flush_r      <= 1'b0;
			flush_addr_r <= '0;
			fault_r      <= 1'b0;
		end else begin
			busy_r       <= busy_nxt;
			dp_stall_r   <= dp_stall_nxt;
			ch_age_r     <= ch_age_nxt;
			ch_last_r    <= ch_last_nxt;
			recov_r      <= recov_nxt;
			ev_vld_r     <= ev_vld_nxt;
			od_vld_r     <= od_vld_nxt;
			ev_addr_r    <= ev_addr_nxt;
			od_addr_r    <= od_addr_nxt;
			ev_cls_r     <= ev_cls_nxt;
			od_cls_r     <= od_cls_nxt;
			flush_r      <= flush_nxt;
			flush_addr_r <= flush_addr_nxt;
			fault_r      <= fault_nxt;
		end
	end

	// ----------------------------------------
	// Multiplier
	// ----------------------------------------
	// narrow multiply only
	vcdi_mul16 vcdi_mul16_i (
		.clk  (clk),
		.rstn (rstn),
		.go   (ev_vld_nxt && ev_cls_nxt == CLS_MPY16),
		.op_a (mul_a),
		.op_b (mul_b),
		.prod (mul_prod)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_misalign_fault: assert property (@(posedge clk) disable iff (!rstn)
		bad[0] && recov_r == '0 |=> fault_r && !ev_vld_r && !od_vld_r)
		else $error("misaligned instruction not faulted");
	a_pipe_one_each: assert property (@(posedge clk) disable iff (!rstn)
		go[0] && go[1] |-> pipe_of(slot_cls[0]) != pipe_of(slot_cls[1]))
		else $error("two issues into one pipe");
	a_dp_spacing: assert property (@(posedge clk) disable iff (!rstn)
		ev_vld_r && ev_cls_r == CLS_DP_FLOAT |=> !(ev_vld_r && ev_cls_r == CLS_DP_FLOAT) [*6])
		else $error("double precision issued inside its stall");
	a_src_hold: assert property (@(posedge clk) disable iff (!rstn)
		go[0] && slot_src_en[0][0] |-> busy_r[slot_src[0][0]] == '0)
		else $error("issued with busy source");
	a_link_lat: assert property (@(posedge clk) disable iff (!rstn)
		go[0] && slot_cls[0] == CLS_BR_LINK && slot_dst_en[0]
		|=> busy_r[$past(slot_dst[0])] == 4'h3 ##3 busy_r[$past(slot_dst[0], 4)] == '0)
		else $error("link latency wrong");
	a_chan_block: assert property (@(posedge clk) disable iff (!rstn)
		go[0] && is_chan(slot_cls[0]) && slot_chan_blk[0] |-> chan_cnt_nz[slot_chan[0]])
		else $error("blocking channel issued at zero count");
	a_chan_retry: assert property (@(posedge clk) disable iff (!rstn)
		ready[0] && retry[0] |=> flush_r && flush_addr_r == $past(slot_addr[0]) && !od_vld_r)
		else $error("close channel access not retried");
	a_recov_quiet: assert property (@(posedge clk) disable iff (!rstn)
		flush_r |=> (!ev_vld_r && !od_vld_r) [*5])
		else $error("progress during flush recovery");

endmodule : vcdi_issue_ctl

/* tb/vcdi_chan_model.sv */
// Channel side model: per-channel count flags that fill after a requested delay
`timescale 1ns/1ps
module vcdi_chan_model (
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           rstn,
	// Fill request from the bench
	input  wire logic                           req,
	input  wire logic [vcdi_pkg::CHAN_W-1:0]    req_ch,
	input  wire logic [7:0]                     req_dly,
	// Count flags
	output logic      [vcdi_pkg::NUM_CHANS-1:0] chan_cnt_nz
);
	import vcdi_pkg::*;
	logic [7:0]        wait_r;
	logic [CHAN_W-1:0] ch_r;
	logic              busy_r;
	// A slow channel: the flag rises only after the delay has run out
	always_ff @(posedge clk) begin
		if (!rstn) begin
			chan_cnt_nz <= '0;
			busy_r      <= 1'b0;
			wait_r      <= 8'h00;
			ch_r        <= '0;
		end else if (req) begin
			busy_r <= 1'b1;
			wait_r <= req_dly;
			ch_r   <= req_ch;
		end else if (busy_r && wait_r == 8'h00) begin
			chan_cnt_nz[ch_r] <= 1'b1;
			busy_r            <= 1'b0;
		end else if (busy_r) begin
			wait_r <= wait_r - 8'h01;
		end
	end
endmodule : vcdi_chan_model

/* tb/vcdi_issue_ctl_tb.sv */
// Self-checking bench for the dual-issue scheduler
`timescale 1ns/1ps
module vcdi_issue_ctl_tb;
	import vcdi_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	typedef struct {vcdi_cls_e cls; logic de; logic odd; int wt;} vcdi_row_s;
	logic                 clk, rstn, req;
	logic                 slot_vld [2], slot_dst_en [2], slot_chan_blk [2], slot_take [2];
	logic [31:0]          slot_addr [2];
	vcdi_cls_e            slot_cls [2];
	logic [REG_W-1:0]     slot_src [2][2];
	logic [1:0]           slot_src_en [2];
	logic [REG_W-1:0]     slot_dst [2];
	logic [CHAN_W-1:0]    slot_chan [2], req_ch;
	logic [NUM_CHANS-1:0] chan_cnt_nz;
	logic [MUL_W-1:0]     mul_a, mul_b;
	logic [2*MUL_W-1:0]   mul_prod, prod;
	logic                 ev_vld_r, od_vld_r, flush_r, fault_r;
	logic [31:0]          ev_addr_r, od_addr_r, flush_addr_r, fl_a;
	vcdi_cls_e            ev_cls_r, od_cls_r;
	logic [7:0]           req_dly;
	int                   bad_count, total_checks, ev_n, od_n, fl_n, fa_n, cyc, tk, w, t0;
	int                   e0, o0, f0;
	vcdi_row_s            rows [5];

	vcdi_issue_ctl vcdi_issue_ctl_i (.clk(clk), .rstn(rstn), .slot_vld(slot_vld),
		.slot_addr(slot_addr), .slot_cls(slot_cls), .slot_src(slot_src),
		.slot_src_en(slot_src_en), .slot_dst(slot_dst), .slot_dst_en(slot_dst_en),
		.slot_chan(slot_chan), .slot_chan_blk(slot_chan_blk), .slot_take(slot_take),
		.chan_cnt_nz(chan_cnt_nz), .mul_a(mul_a), .mul_b(mul_b), .mul_prod(mul_prod),
		.ev_vld_r(ev_vld_r), .ev_addr_r(ev_addr_r), .ev_cls_r(ev_cls_r),
		.od_vld_r(od_vld_r), .od_addr_r(od_addr_r), .od_cls_r(od_cls_r),
		.flush_r(flush_r), .flush_addr_r(flush_addr_r), .fault_r(fault_r));
	vcdi_chan_model vcdi_chan_model_i (.clk(clk), .rstn(rstn), .req(req), .req_ch(req_ch),
		.req_dly(req_dly), .chan_cnt_nz(chan_cnt_nz));

	// ----------------------------------------
	// Clock, cycle count and output monitor
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	// Pulses stand one cycle, so they are counted at every falling edge
	always @(negedge clk) begin
		if (ev_vld_r === 1'b1) ev_n++;
		if (ev_vld_r === 1'b1 && ev_cls_r === CLS_MPY16) prod = mul_prod;
		if (od_vld_r === 1'b1) od_n++;
		if (fault_r === 1'b1) fa_n++;
		if (flush_r === 1'b1) begin
			fl_n++;
			fl_a = flush_addr_r;
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic chk_cls(input vcdi_cls_e got, input vcdi_cls_e exp, input string m);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s class %s", $time, m, got.name());
		end
	endtask : chk_cls
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim
	// Source 0 and target always use register 9; only the enables vary
	task automatic show(input int s, input vcdi_cls_e c, input logic [31:0] a,
		input logic se, input logic de, input logic [CHAN_W-1:0] ch, input logic blk);
		slot_vld[s]      <= 1'b1;
		slot_cls[s]      <= c;
		slot_addr[s]     <= a;
		slot_src[s][0]   <= 7'h09;
		slot_src_en[s]   <= {1'b0, se};
		slot_dst[s]      <= 7'h09;
		slot_dst_en[s]   <= de;
		slot_chan[s]     <= ch;
		slot_chan_blk[s] <= blk;
	endtask : show
	// Candidate stays presented until taken; the next call or idle replaces it
	task automatic put(input vcdi_cls_e c, input logic [31:0] a, input logic se,
		input logic de, input logic [CHAN_W-1:0] ch, input logic blk);
		@(posedge clk);
		show(0, c, a, se, de, ch, blk);
		w = 0;
		@(negedge clk);
		while (slot_take[0] !== 1'b1 && w < 60) begin
			w++;
			@(negedge clk);
		end
		if (w >= 60) chk(32'h0, 32'h1, "candidate never taken");
		tk = cyc;
	endtask : put
	task automatic idle(input int n);
		@(posedge clk);
		slot_vld[0] <= 1'b0;
		slot_vld[1] <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : idle
	task automatic pair(input logic [CHAN_W-1:0] c1, input logic [CHAN_W-1:0] c2,
		input int fl);
		f0 = fl_n;
		put(CLS_CH_WRITE, 32'h500, 1'b0, 1'b0, c1, 1'b0);
		put(CLS_CH_COUNT, 32'h504, 1'b0, 1'b0, c2, 1'b0);
		idle(9);
		chk(fl_n - f0, fl, "retry count");
		if (fl == 1) chk(fl_a, 32'h504, "retry address");
	endtask : pair

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		#(25 * 5000);
		bad_count++;
		end_sim();
	end
	initial begin
		rstn = 1'b0;
		req = 1'b0;
		req_ch = '0;
		req_dly = 8'h00;
		mul_a = 16'hffff;
		mul_b = 16'hffff;
		for (int i = 0; i < 2; i++) begin
			slot_vld[i] = 1'b0;
			slot_addr[i] = 32'h0;
			slot_cls[i] = CLS_ADD_LOGIC;
			slot_src[i][0] = '0;
			slot_src[i][1] = '0;
			slot_src_en[i] = 2'h0;
			slot_dst[i] = '0;
			slot_dst_en[i] = 1'b0;
			slot_chan[i] = '0;
			slot_chan_blk[i] = 1'b0;
		end
		// Wait expected from a dependent presented right after its producer
		rows = '{'{CLS_ADD_LOGIC, 1'b1, 1'b0, 1}, '{CLS_BYTE_AVG, 1'b1, 1'b0, 3},
			'{CLS_BR_IND, 1'b0, 1'b1, 0}, '{CLS_BR_LINK, 1'b1, 1'b1, 3},
			'{CLS_MPY16, 1'b1, 1'b0, 6}};
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			e0 = ev_n;
			o0 = od_n;
			put(rows[i].cls, 32'h40 + 32'(i * 8), 1'b0, rows[i].de, '0, 1'b0);
			put(CLS_ADD_LOGIC, 32'h44 + 32'(i * 8), 1'b1, 1'b0, '0, 1'b0);
			idle(2);
			chk(w, rows[i].wt, "dependent wait");
			chk(ev_n - e0, rows[i].odd ? 1 : 2, "even issues");
			chk(od_n - o0, rows[i].odd ? 1 : 0, "odd issues");
			$display("row %0d done", i);
		end
		chk(prod, 32'hfffe0001, "product");
		put(CLS_DP_FLOAT, 32'h80, 1'b0, 1'b0, '0, 1'b0);
		t0 = tk;
		put(CLS_DP_FLOAT, 32'h84, 1'b0, 1'b0, '0, 1'b0);
		idle(2);
		chk(tk - t0, STALL_DP + 1, "double stall spacing");
		$display("stall test done");
		pair(7'h03, 7'h03, 1);
		pair(EVENT_STATUS_CHANNEL, EVENT_ACKNOWLEDGE_CHANNEL, 1);
		pair(7'h14, 7'h15, 0);
		$display("channel retry test done");
		@(posedge clk);
		req <= 1'b1;
		req_ch <= 7'h0a;
		req_dly <= 8'h0a;
		@(posedge clk);
		req <= 1'b0;
		put(CLS_CH_READ, 32'h600, 1'b0, 1'b0, 7'h0a, 1'b1);
		idle(8);
		chk(w, 32'h0a, "blocking hold");
		$display("blocking test done");
		o0 = od_n;
		put(CLS_SYNC_FLUSH, 32'h100, 1'b0, 1'b0, '0, 1'b0);
		put(CLS_ADD_LOGIC, 32'h200, 1'b0, 1'b0, '0, 1'b0);
		idle(2);
		chk(fl_a, 32'h104, "flush refetch");
		chk(w, FLUSH_RECOV, "recovery stall");
		chk(od_n - o0, 1, "flush op issue");
		e0 = ev_n;
		f0 = fa_n;
		put(CLS_ADD_LOGIC, 32'h302, 1'b0, 1'b0, '0, 1'b0);
		idle(2);
		chk(fa_n - f0, 1, "misaligned fault");
		chk(ev_n - e0, 0, "misaligned issue");
		$display("flush and fault tests done");
		@(posedge clk);
		show(0, CLS_ADD_LOGIC, 32'h400, 1'b0, 1'b0, '0, 1'b0);
		show(1, CLS_BR_LINK, 32'h404, 1'b0, 1'b0, '0, 1'b0);
		@(negedge clk);
		chk(slot_take[1], 1, "odd pair");
		@(posedge clk);
		show(0, CLS_BYTE_AVG, 32'h408, 1'b0, 1'b0, '0, 1'b0);
		show(1, CLS_ADD_LOGIC, 32'h40c, 1'b0, 1'b0, '0, 1'b0);
		@(negedge clk);
		chk({slot_take[0], slot_take[1]}, 2'h2, "same pipe pair");
		chk(ev_addr_r, 32'h400, "even address");
		chk(od_addr_r, 32'h404, "odd address");
		chk_cls(od_cls_r, CLS_BR_LINK, "odd class");
		idle(3);
		$display("dual issue test done");
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk_cls(ev_cls_r, CLS_ADD_LOGIC, "even class at reset");
		chk_cls(od_cls_r, CLS_BR_IND, "odd class at reset");
		chk({28'h0, ev_vld_r, od_vld_r, flush_r, fault_r}, 32'h0, "pulses at reset");
		chk(ev_addr_r, 32'h0, "even address at reset");
		chk(od_addr_r, 32'h0, "odd address at reset");
		chk(flush_addr_r, 32'h0, "flush address at reset");
		chk(mul_prod, 32'h0, "product at reset");
		$display("reset test done");
		end_sim();
	end
endmodule : vcdi_issue_ctl_tb
